// ==== core/lowlat_mode_pkg.sv ====
/*
 * Types shared by the mode and write path: command request and write word.
 * Assumes the constants header is compiled alongside.
 */
package lowlat_mode_pkg;
  typedef struct packed {
    logic [2:0] bank;
    logic [21:0] addr;
  } cmd_req_t;
  typedef struct packed {
    logic [2:0] bank;
    logic [21:0] addr;
    logic [2:0] beat;
  } wr_word_t;
endpackage

// ==== core/lowlat_mode_regs.svh ====
/*
 * Mode register field positions, reset value, latency table and timing counts.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef LOWLAT_MODE_REGS_SVH
`define LOWLAT_MODE_REGS_SVH
`define MODE_W 18
`define MODE_RESET 18'h00000
`define CFG_LO_POS 0
`define CFG_HI_POS 2
`define BL_LO_POS 3
`define BL_HI_POS 4
`define MUX_POS 5
`define DLL_POS 7
`define IMP_POS 8
`define ODT_POS 9
`define MUX_PART_W 11
`define BL_CODE_2 2'h0
`define BL_CODE_4 2'h1
`define BL_CODE_8 2'h2
`define RL_CFG1 4'h4
`define RL_CFG2 4'h6
`define RL_CFG3 4'h8
`define RL_CFG4 4'h3
`define RL_CFG5 4'h5
`define DLL_LOCK_CYCLES 11'h400
`define CLK_MHZ 100
`define CAL_PERIOD_US 100
`define CAL_CYCLES (`CAL_PERIOD_US * `CLK_MHZ)
`endif

// ==== core/lowlat_mode_write.sv ====
/*
 * Mode register, command decode with optional two-part addressing, impedance
 * recalibration tick, termination control and the burst write capture path.
 * Assumes commands arrive on clk_i from a controller on the same clock; the
 * write data clock, data and mask come from outside and are synchronised here.
 */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "lowlat_mode_regs.svh"
module lowlat_mode_write
  import lowlat_mode_pkg::*;
#(
  parameter int DATA_W = 9,
  parameter logic [4:0] ADDR_TOP_BL2 = 5'd21,
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic ref_n_i,
  input wire logic [21:0] addr_i,
  input wire logic [2:0] bank_i,
  input wire logic dk_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic dm_i,
  input wire logic read_drive_i,
  output logic [3:0] row_cycle_o,
  output logic [3:0] read_latency_o,
  output logic [3:0] write_latency_o,
  output logic [3:0] burst_words_o,
  output logic [4:0] addr_top_o,
  output logic addr_mux_o,
  output logic dll_enable_o,
  output logic dll_locked_o,
  output logic impedance_external_o,
  output logic cal_update_o,
  output logic dq_term_o,
  output logic dm_term_o,
  output logic mode_load_o,
  output logic read_cmd_o,
  output logic refresh_o,
  output cmd_req_t cmd_req_o,
  output logic wr_valid_o,
  output wr_word_t wr_word_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic wr_done_o
);
  typedef enum logic [1:0] {C_FIRST, C_SECOND} cmd_state_t;
  typedef enum logic [1:0] {K_READ, K_WRITE, K_LOAD} cmd_kind_t;
  typedef enum logic [1:0] {W_IDLE, W_LAT, W_ARM, W_BURST} wr_state_t;

  logic [`MODE_W-1:0] mode_q, mode_d;
  cmd_state_t cst_q, cst_d;
  cmd_kind_t kind_q, kind_d;
  logic [2:0] pbank_q, pbank_d;
  logic [`MUX_PART_W-1:0] part_q, part_d;
  logic mode_load_q, mode_load_d;
  logic read_q, read_d;
  logic ref_q, ref_d;
  cmd_req_t req_q, req_d;
  logic wr_start;
  cmd_req_t wr_req;
  logic [21:0] addr_mask;
  logic [21:0] mux_addr;
  logic [2:0] cfg;
  logic [1:0] bl;

  // latency table shared by read, write and row cycle
  function automatic logic [3:0] lat_of(input logic [2:0] c);
    case (c)
      3'h0: lat_of = `RL_CFG1;
      3'h1: lat_of = `RL_CFG2;
      3'h2: lat_of = `RL_CFG3;
      3'h3: lat_of = `RL_CFG4;
      3'h4: lat_of = `RL_CFG5;
      default: lat_of = `RL_CFG1;
    endcase
  endfunction

  assign cfg = mode_q[`CFG_HI_POS:`CFG_LO_POS];
  assign bl = mode_q[`BL_HI_POS:`BL_LO_POS];
  assign row_cycle_o = lat_of(cfg);
  assign read_latency_o = lat_of(cfg);
  assign write_latency_o = lat_of(cfg) + 4'h1;
  // reserved burst code falls back to two words
  assign burst_words_o = (bl == `BL_CODE_8) ? 4'h8 : (bl == `BL_CODE_4) ? 4'h4 : 4'h2;
  assign addr_top_o = (bl == `BL_CODE_8) ? ADDR_TOP_BL2 - 5'd2 :
                      (bl == `BL_CODE_4) ? ADDR_TOP_BL2 - 5'd1 : ADDR_TOP_BL2;
  assign addr_mask = 22'h3fffff >> (5'd21 - addr_top_o);
  assign addr_mux_o = mode_q[`MUX_POS];
  assign dll_enable_o = mode_q[`DLL_POS];
  assign impedance_external_o = mode_q[`IMP_POS];
  // read path owns the data drivers; data termination yields while it drives, mask termination stays on
  assign dq_term_o = mode_q[`ODT_POS] & ~read_drive_i;
  assign dm_term_o = mode_q[`ODT_POS];
  assign mode_load_o = mode_load_q;
  assign read_cmd_o = read_q;
  assign refresh_o = ref_q;
  assign cmd_req_o = req_q;
  // second part carries the high bits, eleven lines each
  assign mux_addr = {addr_i[`MUX_PART_W-1:0], part_q};

  always_comb begin
    mode_d = mode_q;
    cst_d = C_FIRST;
    kind_d = kind_q;
    pbank_d = pbank_q;
    part_d = part_q;
    mode_load_d = 1'b0;
    read_d = 1'b0;
    ref_d = 1'b0;
    req_d = req_q;
    wr_start = 1'b0;
    wr_req = '{bank: bank_i, addr: addr_i & addr_mask};
    if (cst_q == C_SECOND) begin
      // second edge completes the pending command whatever the pins decode to
      req_d = '{bank: pbank_q, addr: mux_addr & addr_mask};
      case (kind_q)
        K_LOAD: begin
          mode_d = mux_addr[`MODE_W-1:0];
          mode_load_d = 1'b1;
        end
        K_READ: read_d = 1'b1;
        default: ;
      endcase
    end else if (!cs_n_i) begin
      if (!ref_n_i && we_n_i) begin
        // refresh is single edge in both addressing modes
        ref_d = 1'b1;
        req_d = '{bank: bank_i, addr: 22'h000000};
      end else if (mode_q[`MUX_POS]) begin
        cst_d = C_SECOND;
        pbank_d = bank_i;
        part_d = addr_i[`MUX_PART_W-1:0];
        kind_d = !ref_n_i ? K_LOAD : we_n_i ? K_READ : K_WRITE;
        wr_start = ref_n_i && !we_n_i;
      end else if (!ref_n_i) begin
        mode_d = addr_i[`MODE_W-1:0];
        mode_load_d = 1'b1;
      end else if (we_n_i) begin
        read_d = 1'b1;
        req_d = '{bank: bank_i, addr: addr_i & addr_mask};
      end else begin
        wr_start = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= `MODE_RESET;
      cst_q <= C_FIRST;
      kind_q <= K_READ;
      pbank_q <= 3'h0;
      part_q <= '0;
      mode_load_q <= 1'b0;
      read_q <= 1'b0;
      ref_q <= 1'b0;
      req_q <= '0;
    end else begin
      mode_q <= mode_d;
      cst_q <= cst_d;
      kind_q <= kind_d;
      pbank_q <= pbank_d;
      part_q <= part_d;
      mode_load_q <= mode_load_d;
      read_q <= read_d;
      ref_q <= ref_d;
      req_q <= req_d;
    end
  end

  // loop lock timer and recalibration tick, independent of command flow
  logic [10:0] dll_cnt_q, dll_cnt_d;
  logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_q, cal_cnt_d;
  logic cal_q, cal_d;

  always_comb begin
    dll_cnt_d = dll_cnt_q;
    if (!mode_q[`DLL_POS]) begin
      dll_cnt_d = 11'h000;
    end else if (dll_cnt_q != `DLL_LOCK_CYCLES) begin
      dll_cnt_d = dll_cnt_q + 11'h001;
    end
    cal_d = 1'b0;
    cal_cnt_d = cal_cnt_q + 1'b1;
    if (cal_cnt_q == ($bits(cal_cnt_q))'(CAL_CYCLES - 1)) begin
      // tick only; nothing in the command or write path depends on it
      cal_cnt_d = '0;
      cal_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dll_cnt_q <= 11'h000;
      cal_cnt_q <= '0;
      cal_q <= 1'b0;
    end else begin
      dll_cnt_q <= dll_cnt_d;
      cal_cnt_q <= cal_cnt_d;
      cal_q <= cal_d;
    end
  end

  // counter clears one edge after the bit drops, so the bit gates the flag at once
  assign dll_locked_o = mode_q[`DLL_POS] && (dll_cnt_q == `DLL_LOCK_CYCLES);
  assign cal_update_o = cal_q;

  // data clock, data and mask share one three-stage pipe so they stay aligned
  logic [DATA_W+1:0] s1_q, s2_q, s3_q;
  logic dk_lvl_q, dk_lvl_d;
  logic dk_edge, dk_rise;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dk_lvl_q <= 1'b0;
    end else begin
      s1_q <= {dk_i, dm_i, dq_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      dk_lvl_q <= dk_lvl_d;
    end
  end

  assign dk_edge = (s2_q[DATA_W+1] == s3_q[DATA_W+1]) && (s3_q[DATA_W+1] != dk_lvl_q);
  assign dk_rise = dk_edge && s3_q[DATA_W+1];
  assign dk_lvl_d = dk_edge ? s3_q[DATA_W+1] : dk_lvl_q;

  wr_state_t wst_q, wst_d;
  logic [3:0] lat_q, lat_d;
  logic [3:0] beat_q, beat_d;
  logic [2:0] wbank_q, wbank_d;
  logic [21:0] waddr_q, waddr_d;
  logic wvalid_q, wvalid_d;
  wr_word_t wword_q, wword_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic wdone_q, wdone_d;
  logic take;

  always_comb begin
    wst_d = wst_q;
    lat_d = lat_q;
    beat_d = beat_q;
    wbank_d = wbank_q;
    waddr_d = waddr_q;
    wvalid_d = 1'b0;
    wword_d = wword_q;
    wdata_d = wdata_q;
    wdone_d = 1'b0;
    take = 1'b0;
    // mux address lands one edge after the command; latency is at least four
    if (cst_q == C_SECOND && kind_q == K_WRITE) begin
      waddr_d = mux_addr & addr_mask;
    end
    case (wst_q)
      W_IDLE: begin
        // one burst at a time; a write during a burst is dropped
        if (wr_start) begin
          wst_d = W_LAT;
          lat_d = write_latency_o - 4'h1;
          wbank_d = wr_req.bank;
          waddr_d = wr_req.addr;
          beat_d = 4'h0;
        end
      end
      W_LAT: begin
        lat_d = lat_q - 4'h1;
        if (lat_q == 4'h1) begin
          wst_d = W_ARM;
        end
      end
      W_ARM: begin
        if (dk_rise) begin
          wst_d = W_BURST;
          take = 1'b1;
        end
      end
      W_BURST: begin
        take = dk_edge;
      end
      default: wst_d = W_IDLE;
    endcase
    if (take) begin
      beat_d = beat_q + 4'h1;
      wvalid_d = ~s3_q[DATA_W];
      wword_d = '{bank: wbank_q, addr: waddr_q, beat: beat_q[2:0]};
      wdata_d = s3_q[DATA_W-1:0];
      // burst length read live; a change mid burst corrupts it
      if (beat_q + 4'h1 == burst_words_o) begin
        wst_d = W_IDLE;
        wdone_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wst_q <= W_IDLE;
      lat_q <= 4'h0;
      beat_q <= 4'h0;
      wbank_q <= 3'h0;
      waddr_q <= 22'h000000;
      wvalid_q <= 1'b0;
      wword_q <= '0;
      wdata_q <= '0;
      wdone_q <= 1'b0;
    end else begin
      wst_q <= wst_d;
      lat_q <= lat_d;
      beat_q <= beat_d;
      wbank_q <= wbank_d;
      waddr_q <= waddr_d;
      wvalid_q <= wvalid_d;
      wword_q <= wword_d;
      wdata_q <= wdata_d;
      wdone_q <= wdone_d;
    end
  end

  assign wr_valid_o = wvalid_q;
  assign wr_word_o = wword_q;
  assign wr_data_o = wdata_q;
  assign wr_done_o = wdone_q;
endmodule

// ==== verification/lowlat_mode_write_props.sv ====
/* checker for lowlat_mode_write, port signals only.
   assumes a bind from the bench top; one clock domain. */
module lowlat_mode_write_props
  import lowlat_mode_pkg::*;
#(
  parameter logic [4:0] ADDR_TOP_BL2 = 5'd21,
  parameter int CAL_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic ref_n_i,
  input wire logic [21:0] addr_i,
  input wire logic [2:0] bank_i,
  input wire logic read_drive_i,
  input wire logic [3:0] row_cycle_o,
  input wire logic [3:0] read_latency_o,
  input wire logic [3:0] write_latency_o,
  input wire logic [3:0] burst_words_o,
  input wire logic [4:0] addr_top_o,
  input wire logic addr_mux_o,
  input wire logic dll_enable_o,
  input wire logic dll_locked_o,
  input wire logic cal_update_o,
  input wire logic dq_term_o,
  input wire logic dm_term_o,
  input wire logic mode_load_o,
  input wire logic read_cmd_o,
  input wire logic refresh_o,
  input wire cmd_req_t cmd_req_o,
  input wire logic wr_valid_o,
  input wire wr_word_t wr_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [10:0] lock_q;
  logic [15:0] gap_q;
  logic seen_q;
  // own lock counter, kept apart from the design's so a short count shows up
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_q <= '0;
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      lock_q <= !dll_enable_o ? '0 : (lock_q == 11'h7ff ? lock_q : lock_q + 11'h1);
      gap_q <= cal_update_o ? '0 : gap_q + 16'h1;
      seen_q <= seen_q | cal_update_o;
    end
  end
  sequence mux_rd_s;
    addr_mux_o && !cs_n_i && we_n_i && ref_n_i;
  endsequence
  sequence rd_answer_s;
    ##2 read_cmd_o && cmd_req_o.bank == $past(bank_i, 2)
      && cmd_req_o.addr[10:0] == $past(addr_i[10:0], 2);
  endsequence
  latency_pair_a: assert property (write_latency_o == read_latency_o + 4'h1
    && row_cycle_o == read_latency_o) else $error("latency pair broken");
  term_split_a: assert property (dq_term_o == (dm_term_o && !read_drive_i))
    else $error("termination mismatch");
  mode_load_a: assert property (!addr_mux_o && !cs_n_i && !we_n_i && !ref_n_i |=>
    mode_load_o && addr_mux_o == $past(addr_i[5]) && dll_enable_o == $past(addr_i[7]))
    else $error("mode load not taken");
  refresh_one_a: assert property (!cs_n_i && we_n_i && !ref_n_i |=>
    refresh_o && cmd_req_o.bank == $past(bank_i)) else $error("refresh not taken");
  mux_read_a: assert property (mux_rd_s |-> rd_answer_s)
    else $error("mux read wrong");
  addr_width_a: assert property (addr_top_o == ADDR_TOP_BL2
    - (burst_words_o == 4'h4 ? 5'h1 : (burst_words_o == 4'h8 ? 5'h2 : 5'h0)))
    else $error("address width wrong");
  dll_lock_a: assert property (dll_locked_o |-> dll_enable_o && lock_q >= 11'd1024)
    else $error("lock too early");
  dll_wait_a: assert property (lock_q == 11'd1024 |-> dll_locked_o)
    else $error("lock missing");
  cal_period_a: assert property (cal_update_o && seen_q |-> gap_q == CAL_CYCLES - 1)
    else $error("recalibration period wrong");
  beat_range_a: assert property (wr_valid_o |-> {1'b0, wr_word_o.beat} < burst_words_o)
    else $error("beat beyond burst");
endmodule

// ==== verification/tb_top.sv ====
/* bench for lowlat_mode_write: mode loads, mux commands, a masked burst.
   assumes wr_ctrl_model drives the data clock, data and mask pins. */
module tb_top
  import lowlat_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, reset_n_i = 1'b0, cs_n_i = 1'b1, we_n_i = 1'b1, ref_n_i = 1'b1;
  logic [21:0] addr_i = '0;
  logic [2:0] bank_i = '0;
  logic read_drive_i = 1'b0, go = 1'b0, dk_i, dm_i;
  logic [8:0] dq_i, wr_data_o;
  logic [3:0] row_cycle_o, read_latency_o, write_latency_o, burst_words_o;
  logic [4:0] addr_top_o;
  logic addr_mux_o, dll_enable_o, dll_locked_o, impedance_external_o, cal_update_o;
  logic dq_term_o, dm_term_o, mode_load_o, read_cmd_o, refresh_o, wr_valid_o, wr_done_o;
  cmd_req_t cmd_req_o;
  wr_word_t wr_word_o;
  int num_errors = 0, comparisons = 0, n, d;
  int rl[5] = '{4, 6, 8, 3, 5};
  logic [2:0] beats[3] = '{3'h0, 3'h2, 3'h3};
  lowlat_mode_write #(.CAL_CYCLES(20)) i_lowlat_mode_write (.*);
  wr_ctrl_model i_wr_ctrl_model (.go_i(go), .words_i(4'h4), .mask_i(8'h02), .dk_o(dk_i),
    .dq_o(dq_i), .dm_o(dm_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // mux commands take a second edge; bank moves there to prove it is ignored
  task automatic cmd(input logic we, input logic rf, input logic [21:0] a, input logic mx);
    @(posedge clk_i);
    cs_n_i <= 1'b0;
    we_n_i <= we;
    ref_n_i <= rf;
    addr_i <= mx ? {11'h0, a[10:0]} : a;
    bank_i <= 3'h6;
    @(posedge clk_i);
    cs_n_i <= 1'b1;
    addr_i <= {11'h0, a[21:11]};
    bank_i <= 3'h1;
    if (mx) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    chk(read_latency_o, 4);
    chk({addr_mux_o, dll_enable_o, dq_term_o, dm_term_o}, 0);
    for (int c = 0; c < 5; c++) begin
      cmd(0, 0, 22'(c), 0);
      chk(mode_load_o, 1);
      chk(read_latency_o, rl[c]);
      chk(write_latency_o, rl[c] + 1);
      chk(row_cycle_o, rl[c]);
    end
    for (int k = 0; k < 3; k++) begin
      // burst eight is paired with the second configuration, never the first or fourth
      cmd(0, 0, 22'((k << 3) | 1), 0);
      chk(burst_words_o, 2 << k);
      chk(addr_top_o, 21 - k);
    end
    cmd(0, 0, 22'h300, 0);
    chk({impedance_external_o, dq_term_o, dm_term_o}, 3'h7);
    @(posedge clk_i);
    read_drive_i <= 1'b1;
    @(negedge clk_i);
    chk({dq_term_o, dm_term_o}, 2'h1);
    @(posedge clk_i);
    read_drive_i <= 1'b0;
    cmd(0, 0, 22'h080, 0);
    chk(dll_locked_o, 0);
    repeat (1100) @(negedge clk_i);
    chk({dll_enable_o, dll_locked_o}, 2'h3);
    cmd(0, 0, 22'h00b, 0);
    chk(dll_locked_o, 0);
    cmd(0, 1, 22'h1234, 0);
    repeat (4) @(posedge clk_i);
    go <= 1'b1;
    n = 0;
    d = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (wr_valid_o === 1'b1) begin
        if (n < 3) chk(wr_word_o, {3'h6, 22'h1234, beats[n]});
        if (n < 3) chk(wr_data_o, 9'h0a0 + 9'(beats[n]));
        n++;
      end
      if (wr_done_o === 1'b1) d++;
    end
    chk(n, 3);
    chk(d, 1);
    cmd(0, 0, 22'h020, 0);
    chk(addr_mux_o, 1);
    cmd(1, 1, 22'h2d51c7, 1);
    chk(read_cmd_o, 1);
    chk(cmd_req_o, {3'h6, 22'h2d51c7});
    @(posedge clk_i);
    cs_n_i <= 1'b0;
    we_n_i <= 1'b1;
    ref_n_i <= 1'b0;
    bank_i <= 3'h3;
    @(posedge clk_i);
    bank_i <= 3'h5;
    @(negedge clk_i);
    chk({refresh_o, cmd_req_o.bank}, 4'hb);
    @(posedge clk_i);
    cs_n_i <= 1'b1;
    @(negedge clk_i);
    chk({refresh_o, cmd_req_o.bank}, 4'hd);
    test_done();
  end
endmodule
bind lowlat_mode_write lowlat_mode_write_props #(.ADDR_TOP_BL2(ADDR_TOP_BL2),
  .CAL_CYCLES(CAL_CYCLES)) i_props (.*);

// ==== verification/wr_ctrl_model.sv ====
/* controller model: data clock, data and mask for one write burst.
   assumes a start pulse from the bench once write latency has run. */
module wr_ctrl_model #(
  parameter int DATA_W = 9
) (
  input wire logic go_i,
  input wire logic [3:0] words_i,
  input wire logic [7:0] mask_i,
  output logic dk_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    dk_o = 1'b0;
    dq_o = '0;
    dm_o = 1'b0;
  end
  // clock stands still between bursts; lines show garbage once released
  always @(posedge go_i) begin
    for (int b = 0; b < words_i; b++) begin
      dq_o = DATA_W'(9'h0a0 + b);
      dm_o = mask_i[b];
      #31.25 dk_o = ~dk_o;
      #31.25;
    end
    dq_o = ~dq_o;
    dm_o = ~dm_o;
  end
endmodule
